//--- dmx_core.sv
// output control of a dual sampled converter with a shared output bus
// assumes raw words from both channels arrive on the system clock,
// and the half-rate converter clock is made here from clk_sys_i
// Functional notes
// - both channels sampled on same rising edge
// - five clock periods latency to output
// - first channel word updates on rising edge
// - second channel word half period later
// - indicator lags clock, high for first; here it switches on the same edge as the converter clock
// - format pin selects offset binary or complement
// - sleep disables both conversion channels
// - power down with enable low holds outputs
// - enable high floats the data outputs
// - enable low drives converted data
// - power down low means normal operation
`timescale 1ns/1ps
module dmx_core #(
  parameter int unsigned W = dmx_pkg::WORD_W
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // analog side results, offset binary
  input  wire logic [W-1:0] first_channel_i,
  input  wire logic [W-1:0] second_channel_i,
  // control pins
  input  wire logic         twos_fmt_i,
  input  wire logic         sleep_i,
  input  wire logic         power_down_in_i,
  input  wire logic         out_en_n_i,
  // converter clock, one system clock per half period
  output logic              conv_clk_o,
  // shared output bus and indicator
  output logic      [W-1:0] shared_output_bus_o,
  output logic      [W-1:0] shared_output_bus_oe_o,
  output logic              chan_ind_o,
  output logic              active_o
);
  // refuse widths that leave no bits below the flipped msb
  if (W < 2) begin : g_bad_w
    $error("word width must be at least two");
  end

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  // the control pins are asynchronous, so two flops before any use
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge clk_sys_i) begin
    pin_s1 <= {twos_fmt_i, sleep_i, power_down_in_i, out_en_n_i};
    pin_s2 <= pin_s1;
  end
  // names of the synchronised pins
  wire twos_s = pin_s2[3];
  wire sleep_s = pin_s2[2];
  wire pd_s = pin_s2[1];
  wire oe_n_s = pin_s2[0];

  // ***********************************************
  // converter clock: high phase = rising half
  // ***********************************************
  // phase low means the next half is high, so the edge that raises the
  // converter clock is also the edge that samples both channels
  logic               phase;
  dmx_pkg::dmx_slot_e slot;
  dmx_pkg::dmx_slot_e next_slot;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) phase <= 1'b0;
    else phase <= ~phase;
  end
  wire rise_now = ~phase; // next half is the clock high half
  // sleep and power down both halt sampling and freeze the bus and indicator
  wire run = ~sleep_s & ~pd_s;

  // slot state follows the half periods
  // slot mirrors which word the bus carries; idle while halted
  always_comb begin
    case (slot)
      dmx_pkg::DMX_IDLE:   next_slot = (run && rise_now) ? dmx_pkg::DMX_SLOT_A : dmx_pkg::DMX_IDLE;
      dmx_pkg::DMX_SLOT_A: next_slot = dmx_pkg::DMX_SLOT_B;
      dmx_pkg::DMX_SLOT_B: next_slot = run ? dmx_pkg::DMX_SLOT_A : dmx_pkg::DMX_IDLE;
      default:             next_slot = dmx_pkg::DMX_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) slot <= dmx_pkg::DMX_IDLE;
    else slot <= next_slot;
  end

  // ***********************************************
  // sampling and pipelines
  // ***********************************************
  // sampling strobe: once per converter period, on its rising edge
  wire samp = run & rise_now;
  logic [W-1:0] pipe_a;
  logic [W-1:0] pipe_b;
  // first channel: five periods = ten halves, samples every two
  dmx_pipe #(.W(W), .DEPTH(dmx_pkg::LATENCY_CYCLES)) u_pipe_a (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .adv_i     (samp),
    .d_i       (first_channel_i),
    .q_o       (pipe_a)
  );
  // second channel: same depth and strobe, so a pair never splits
  dmx_pipe #(.W(W), .DEPTH(dmx_pkg::LATENCY_CYCLES)) u_pipe_b (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .adv_i     (samp),
    .d_i       (second_channel_i),
    .q_o       (pipe_b)
  );

  // format: flip msb for two's complement
  wire [W-1:0] fmt_mask = {twos_s, {(W-1){1'b0}}};
  wire [W-1:0] word_a = pipe_a ^ fmt_mask;
  wire [W-1:0] word_b = pipe_b ^ fmt_mask;
  wire         drive = ~oe_n_s;

  // ***********************************************
  // output registers
  // ***********************************************
  // second channel word is parked at the sampling edge: the pipe moves on
  // at that same edge, so reading it half a period later would skip ahead
  logic [W-1:0] b_wait;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      b_wait <= W'(dmx_pkg::DATA_RESET);
    end else if (samp) begin
      b_wait <= word_b;
    end
  end

  // bus and indicator move only while converting, else they hold
  logic [W-1:0] bus_q;
  logic         ind_q;
  logic         clk_q;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bus_q <= W'(dmx_pkg::DATA_RESET);
      ind_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      clk_q <= rise_now;
      if (run && rise_now) begin
        bus_q <= word_a;
        ind_q <= 1'b1;
      end else if (run && !rise_now) begin
        bus_q <= b_wait;
        ind_q <= 1'b0;
      end
      // power down or sleep: bus_q and ind_q hold
    end
  end
  // outputs come straight from the registers above
  assign shared_output_bus_o = bus_q;
  assign conv_clk_o = clk_q;
  assign chan_ind_o = ind_q;

  // per-bit enables and activity flag, registered after the pin sync
  logic [W-1:0] oe_q;
  logic         act_q;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      oe_q  <= '0;
      act_q <= 1'b0;
    end else begin
      oe_q  <= {W{drive}};
      act_q <= run;
    end
  end
  assign shared_output_bus_oe_o = oe_q;
  assign active_o = act_q;

  // ***********************************************
  // checks
  // ***********************************************
  // all checks run on the system clock and rest while reset is low
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  ind_high_a: assert property (run && rise_now |=> chan_ind_o && conv_clk_o)
    else $error("indicator not high in first slot");
  ind_low_a: assert property (run && !rise_now |=> !chan_ind_o && !conv_clk_o)
    else $error("indicator not low in second slot");
  hold_pd_a: assert property (pd_s && $past(pd_s) |=> $stable(shared_output_bus_o))
    else $error("bus changed during power down");
  hold_sleep_a: assert property (sleep_s |=> $stable(shared_output_bus_o))
    else $error("bus changed during sleep");
  float_off_a: assert property (oe_n_s |=> shared_output_bus_oe_o == '0)
    else $error("bus driven while disabled");
  drive_on_a: assert property (!oe_n_s |=> shared_output_bus_oe_o == '1)
    else $error("bus not driven while enabled");
  word_a_a: assert property (run && rise_now |=> shared_output_bus_o == $past(word_a))
    else $error("first channel word wrong");
  word_b_a: assert property (run && !rise_now && $past(run && rise_now) |=>
                             shared_output_bus_o == $past(word_b, 2))
    else $error("second channel word wrong");
  fmt_msb_a: assert property (run && rise_now |=>
    shared_output_bus_o == {$past(pipe_a[W-1]) ^ $past(twos_s), $past(pipe_a[W-2:0])})
    else $error("format bit wrong");
  active_a: assert property (pd_s |=> !active_o)
    else $error("active while powered down");
  act_run_a: assert property (!sleep_s && !pd_s |=> active_o)
    else $error("idle while converting");
  clk_tog_a: assert property (1'b1 |=> conv_clk_o != $past(conv_clk_o))
    else $error("converter clock missed a half period");
  slot_ind_a: assert property (slot == dmx_pkg::DMX_SLOT_A |-> chan_ind_o && conv_clk_o)
    else $error("indicator low in first slot");
  slot_clk_a: assert property (slot == dmx_pkg::DMX_SLOT_B |-> !conv_clk_o)
    else $error("converter clock high in second slot");
  ind_hold_a: assert property (pd_s |=> $stable(chan_ind_o))
    else $error("indicator changed during power down");
  pipe_hold_a: assert property (!run |=> $stable(pipe_a) && $stable(pipe_b))
    else $error("pipeline moved while halted");

  // main scenarios
  slot_a_c: cover property (slot == dmx_pkg::DMX_SLOT_A ##1 slot == dmx_pkg::DMX_SLOT_B);
  pd_c: cover property (run ##1 pd_s);
  float_c: cover property (!oe_n_s ##1 oe_n_s);
  fmt_c: cover property (run && twos_s ##1 chan_ind_o);
  sleep_c: cover property (sleep_s ##1 !active_o);
endmodule

//--- dmx_pkg.sv
// package of constants for the dual converter output block
// assumes a single 25 MHz system clock drives everything
package dmx_pkg;
  // ***********************************************
  // widths and timing
  // ***********************************************
  localparam int unsigned WORD_W         = 10;
  localparam int unsigned LATENCY_CYCLES = 5;
  localparam int unsigned CLK_PERIOD_PS  = 40000;
  localparam int unsigned IND_LAG_PS     = 6000;
  // indicator lag as whole cycles, longest time rounds down, floor of one
  localparam int unsigned IND_LAG_CYCLES =
    (IND_LAG_PS / CLK_PERIOD_PS) < 1 ? 1 : (IND_LAG_PS / CLK_PERIOD_PS);
  localparam logic [9:0] DATA_RESET      = 10'h000;
  localparam logic       MSB_FLIP        = 1'h1;
  // ***********************************************
  // output slot state
  // ***********************************************
  typedef enum logic [1:0] {
    DMX_IDLE   = 2'h0,
    DMX_SLOT_A = 2'h1,
    DMX_SLOT_B = 2'h3
  } dmx_slot_e;
endpackage

//--- dmx_pipe.sv
// delay line carrying converted words through the pipeline
// assumes the caller samples both channels on the same edge
`timescale 1ns/1ps
module dmx_pipe #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 5
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // stream
  input  wire logic         adv_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stage [DEPTH];

  // a pipe without stages cannot delay anything
  if (DEPTH < 1) begin : g_bad_depth
    $error("depth must be at least one");
  end

  // one register per stage
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_st
      always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
          stage[g] <= '0;
        end else if (adv_i) begin
          stage[g] <= (g == 0) ? d_i : stage[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign q_o = stage[DEPTH-1];
endmodule

//--- dmx_capture.sv
// capture model reading the multiplexed output bus
// assumes bus, enables and indicator are registered on clk_sys_i
`timescale 1ns/1ps
module dmx_capture (
  // clock
  input  wire logic       clk_sys_i,
  // bus side
  input  wire logic [9:0] bus_i,
  input  wire logic [9:0] oe_i,
  input  wire logic       ind_i,
  // captured words
  output logic      [9:0] word_a_o,
  output logic      [9:0] word_b_o
);
  // ***********************************
  // wire level and capture
  // ***********************************
  logic [9:0] pin;
  logic [9:0] last = 10'h000;
  // an undriven bit shows the inverse of its last level
  assign pin = (bus_i & oe_i) | (~last & ~oe_i);
  // attribute each word by the indicator level
  always_ff @(posedge clk_sys_i) begin
    last <= pin;
    if (ind_i) word_a_o <= pin;
    else word_b_o <= pin;
  end
endmodule

//--- dmx_core_tb_top.sv
// testbench for the dual converter output block
// assumes a 25 MHz clock and the capture model beside the bus
`timescale 1ns/1ps
module dmx_core_tb_top;
  // ***********************************
  // stimulus and observation
  // ***********************************
  logic       clk_sys_i = 1'b0;
  logic       nrst_i    = 1'b0;
  logic [9:0] a         = 10'h2A5;
  logic [9:0] b         = 10'h15A;
  logic       fmt       = 1'b0;
  logic       slp       = 1'b0;
  logic       pd        = 1'b0;
  logic       oen       = 1'b0;
  logic       ind, act, pi, cclk;
  logic [9:0] bus, oe, wa, wb, hold;
  int         n_mismatch  = 0;
  int         comparisons = 0;
  int         n;
  always #20 clk_sys_i = ~clk_sys_i;
  dmx_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .first_channel_i(a),
    .second_channel_i(b), .twos_fmt_i(fmt), .sleep_i(slp), .power_down_in_i(pd),
    .out_en_n_i(oen), .conv_clk_o(cclk), .shared_output_bus_o(bus),
    .shared_output_bus_oe_o(oe), .chan_ind_o(ind), .active_o(act));
  dmx_capture cap (.clk_sys_i(clk_sys_i), .bus_i(bus), .oe_i(oe), .ind_i(ind),
    .word_a_o(wa), .word_b_o(wb));
  // wait k edges, then settle just after the last one
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  // compare a word
  task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // compare a flag
  task automatic cmp1(input logic got, input logic exp);
    cmp10({9'h000, got}, {9'h000, exp});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish;
  end
  // ***********************************
  // tests
  // ***********************************
  initial begin
    step(10);
    nrst_i = 1'b1;
    step(30);
    cmp10(wa, a);
    cmp10(wb, b);
    pi = ind;
    step(1);
    cmp1(ind, ~pi);
    cmp1(cclk, ind);
    $display("test pairing done");
    a = 10'h0F0;
    b = 10'h30F;
    step(2);
    b = 10'h0C3;
    n = 0;
    while (bus !== a && n < 20) begin
      step(1);
      n++;
    end
    cmp1(n >= 9 && n <= 10, 1'b1);
    cmp1(ind, 1'b1);
    step(1);
    cmp10(bus, 10'h30F);
    $display("test latency done");
    fmt = 1'b1;
    step(30);
    cmp10(wa, a ^ 10'h200);
    cmp10(wb, b ^ 10'h200);
    fmt = 1'b0;
    $display("test format done");
    oen = 1'b1;
    step(6);
    cmp10(oe, 10'h000);
    oen = 1'b0;
    step(6);
    cmp10(oe, 10'h3FF);
    $display("test enable done");
    pd = 1'b1;
    step(6);
    hold = bus;
    a = 10'h001;
    step(30);
    cmp10(bus, hold);
    cmp1(act, 1'b0);
    pd = 1'b0;
    step(30);
    cmp1(act, 1'b1);
    cmp10(wa, a);
    $display("test power down done");
    slp = 1'b1;
    step(6);
    cmp1(act, 1'b0);
    hold = bus;
    step(4);
    cmp10(bus, hold);
    slp = 1'b0;
    $display("test sleep done");
    tally_and_finish;
  end
endmodule
